//--- src/io_space_access_decoder.sv
// Decoder for core accesses to the I/O register space
`timescale 1ns/10ps
`default_nettype none
module io_space_access_decoder #(
    parameter int DATA_WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Core request
    input wire logic req_valid,
    input wire io_space_pkg::access_kind_type req_kind,
    input wire logic [7:0] req_addr,
    input wire logic [2:0] req_bit,
    input wire logic req_write,
    input wire logic [DATA_WIDTH-1:0] req_wdata,
    // Peripheral register port
    output logic reg_sel,
    output logic reg_ext,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic [DATA_WIDTH-1:0] reg_rdata,
    input wire logic [DATA_WIDTH-1:0] reg_w1c_mask,
    // Answer to the core
    output logic resp_valid,
    output logic resp_error,
    output logic [DATA_WIDTH-1:0] resp_rdata,
    output logic resp_skip
);
    // Request kind, one flag per access class
    logic kind_in;
    logic kind_out;
    logic kind_set;
    logic kind_clear;
    logic kind_test;
    logic kind_data;
    logic bit_op;
    // Address classes
    logic upper_clear;
    logic in_bit_window;
    logic in_direct;
    logic is_io_data;
    logic is_ext_data;
    logic [5:0] io_addr;
    logic [7:0] data_io_addr;
    // Acceptance
    logic take;
    logic legal;
    // Bit paths
    logic [DATA_WIDTH-1:0] bit_onehot;
    logic [DATA_WIDTH-1:0] merged;
    // Answer registers
    logic [DATA_WIDTH-1:0] rd_reg;
    logic skip_reg;
    logic valid_reg;
    logic error_reg;

    // Address map as the core sees it:
    //   I/O 0x00..0x1F   bit window: in, out, bit set, bit clear and bit test
    //   I/O 0x20..0x3F   direct window: in and out only
    //   Data 0x20..0x5F  the same 64 registers through loads and stores
    //   Data 0x60..0xFF  extended registers, loads and stores only
    //   Data 0x00..0x1F  not I/O space, refused here
    // The peripheral sees one register address: the I/O address for direct and
    // bit forms, the data address less 0x20 for loads and stores. Extended
    // registers therefore land at 0x40..0xDF, told apart by reg_ext.
    // Reserved addresses inside the windows are passed on; keeping software
    // off them is left to the core.

    // Kind decode; a code that is not one-hot matches no flag and is refused
    always_comb begin
        kind_in = (req_kind == io_space_pkg::ACC_IO_IN);
        kind_out = (req_kind == io_space_pkg::ACC_IO_OUT);
        kind_set = (req_kind == io_space_pkg::ACC_BIT_SET);
        kind_clear = (req_kind == io_space_pkg::ACC_BIT_CLEAR);
        kind_test = (req_kind == io_space_pkg::ACC_BIT_TEST);
        kind_data = (req_kind == io_space_pkg::ACC_DATA);
        bit_op = kind_set || kind_clear;
    end

    // Address classes; the I/O forms need the two upper address bits clear
    always_comb begin
        io_addr = req_addr[5:0];
        upper_clear = (req_addr[7:6] == 2'b00);
        in_bit_window = upper_clear && (io_addr <= io_space_pkg::BIT_WINDOW_LAST);
        in_direct = upper_clear && (io_addr <= io_space_pkg::DIRECT_IO_LAST);
        is_io_data = (req_addr >= io_space_pkg::IO_DATA_OFFSET)
            && (req_addr < io_space_pkg::EXT_IO_FIRST);
        is_ext_data = (req_addr >= io_space_pkg::EXT_IO_FIRST)
            && (req_addr <= io_space_pkg::EXT_IO_LAST);
        // Wraps below 0x20, harmless because such data accesses are refused
        data_io_addr = req_addr - io_space_pkg::IO_DATA_OFFSET;
    end

    // Each kind checks only its own window, so extended registers never
    // answer a direct or single-bit form:
    //   in, out     I/O 0x00..0x3F
    //   bit forms   I/O 0x00..0x1F
    //   data        data 0x20..0xFF
    //   none        never, and no answer at all
    always_comb begin
        take = req_valid && clk_en;
        unique case (req_kind)
            io_space_pkg::ACC_IO_IN,
            io_space_pkg::ACC_IO_OUT: begin
                legal = in_direct;
            end
            io_space_pkg::ACC_BIT_SET,
            io_space_pkg::ACC_BIT_CLEAR,
            io_space_pkg::ACC_BIT_TEST: begin
                legal = in_bit_window;
            end
            io_space_pkg::ACC_DATA: begin
                legal = is_io_data || is_ext_data;
            end
            io_space_pkg::ACC_NONE: begin
                legal = 1'b0;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    // One-hot select of the addressed bit for the test path; a shallow
    // and-or per bit instead of a variable index into the read data
    for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_bit_sel
        assign bit_onehot[i] = (req_bit == 3'(i));
    end

    // Bit set or clear writes back a merged byte that spares other flags
    io_bit_merge #(
        .DATA_WIDTH(DATA_WIDTH)
    ) u_merge (
        .bit_index(req_bit),
        .set_bit(kind_set),
        .current_value(reg_rdata),
        .w1c_mask(reg_w1c_mask),
        .write_value(merged)
    );

    // Timing of one access:
    //   cycle 0  request held by the core; strobes, address and merged data
    //            reach the peripheral, which answers reg_rdata in the same cycle
    //   edge     peripheral commits the write; answer registers capture
    //   cycle 1  resp_valid with resp_error, resp_rdata and resp_skip
    // A low clk_en drops the strobes and freezes every answer register, so a
    // frozen cycle neither writes nor loses the last answer.

    // Register port drive; the peripheral clears its flags on a written one.
    // All strobes are combinational so a bit operation reads, merges and
    // writes back within the one cycle the core holds the request.
    // Hazard: reg_rdata must settle inside that cycle, the merge depends on it.
    always_comb begin
        reg_sel = take && legal;
        reg_ext = kind_data && is_ext_data;
        if (kind_data) begin
            reg_addr = data_io_addr;
        end else begin
            reg_addr = {2'b00, io_addr};
        end
        reg_rd = reg_sel && (bit_op || kind_test || kind_in || (kind_data && !req_write));
        reg_wr = reg_sel && (bit_op || kind_out || (kind_data && req_write));
        reg_wdata = bit_op ? merged : req_wdata;
    end

    // Answer strobe, one cycle after any request that names an access
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            valid_reg <= 1'b0;
        end else if (clk_en) begin
            valid_reg <= take && (req_kind != io_space_pkg::ACC_NONE);
        end
    end

    // Refusal flag rides with the strobe; the core decides what to do with it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            error_reg <= 1'b0;
        end else if (clk_en) begin
            error_reg <= take && (req_kind != io_space_pkg::ACC_NONE) && !legal;
        end
    end

    // Read data held for the answer; zero when the access read nothing,
    // so stale data from an earlier read never looks like a fresh answer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_reg <= io_space_pkg::DATA_RESET;
        end else if (clk_en) begin
            rd_reg <= reg_rd ? reg_rdata : io_space_pkg::DATA_RESET;
        end
    end

    // Skip decision; one flag serves both skip forms, the core inverts it
    // for the skip-if-cleared form, which saves a second test path here
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            skip_reg <= 1'b0;
        end else if (clk_en) begin
            skip_reg <= reg_sel && kind_test && (|(reg_rdata & bit_onehot));
        end
    end

    // Answer outputs straight from their flip-flops
    assign resp_valid = valid_reg;
    assign resp_error = error_reg;
    assign resp_rdata = rd_reg;
    assign resp_skip = skip_reg;
endmodule // io_space_access_decoder
`default_nettype wire

//--- src/io_space_pkg.sv
// Package: I/O space address map constants and access kinds
package io_space_pkg;
    // Widths
    localparam int IO_ADDR_WIDTH = 6;
    localparam int DATA_ADDR_WIDTH = 8;
    localparam int BIT_INDEX_WIDTH = 3;
    // Bit-accessible window, direct I/O range, data-space offset
    localparam logic [5:0] BIT_WINDOW_LAST = 6'h1F;
    localparam logic [5:0] DIRECT_IO_LAST = 6'h3F;
    localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
    localparam logic [7:0] EXT_IO_FIRST = 8'h60;
    localparam logic [7:0] EXT_IO_LAST = 8'hFF;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Access kinds requested by the core
    typedef enum logic [6:0] {
        ACC_NONE = 7'h01,
        ACC_IO_IN = 7'h02,
        ACC_IO_OUT = 7'h04,
        ACC_BIT_SET = 7'h08,
        ACC_BIT_CLEAR = 7'h10,
        ACC_BIT_TEST = 7'h20,
        ACC_DATA = 7'h40
    } access_kind_type;
endpackage : io_space_pkg

//--- src/io_bit_merge.sv
// Single-bit write merge that keeps write-one-to-clear flags intact
`timescale 1ns/10ps
`default_nettype none
module io_bit_merge #(
    parameter int DATA_WIDTH = 8
) (
    // Operation
    input wire logic [2:0] bit_index,
    input wire logic set_bit,
    // Register view
    input wire logic [DATA_WIDTH-1:0] current_value,
    input wire logic [DATA_WIDTH-1:0] w1c_mask,
    // Result written back
    output logic [DATA_WIDTH-1:0] write_value
);
    // Only the addressed bit carries a one where it is a flag; other flags get zero
    always_comb begin
        for (int i = 0; i < DATA_WIDTH; i++) begin
            if (i == int'(bit_index)) begin
                write_value[i] = set_bit;
            end else begin
                write_value[i] = current_value[i] & ~w1c_mask[i];
            end
        end
    end
endmodule // io_bit_merge
`default_nettype wire

//--- verif/io_space_checker.sv
// Concurrent checks on decoder address windows and bit merge
`timescale 1ns/10ps
`default_nettype none
module io_space_checker (
    // Clock and core request
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire io_space_pkg::access_kind_type req_kind,
    input wire logic [7:0] req_addr,
    input wire logic [2:0] req_bit,
    // Register port and answer
    input wire logic reg_sel,
    input wire logic reg_ext,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] reg_w1c_mask,
    input wire logic resp_error
);
    logic go;
    logic [7:0] keep;
    // Flags drop out of the merge, so a zero written there leaves them alone
    assign go = req_valid && clk_en;
    assign keep = reg_rdata & ~reg_w1c_mask;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Kind bits: 1 in, 2 out, 3 set, 4 clear, 5 test, 6 data
    sequence s_refused; !reg_sel ##1 resp_error; endsequence
    property p_bit_window; go && |req_kind[5:3] && req_addr > 8'h1F |-> s_refused; endproperty
    a_bit_window: assert property (p_bit_window) else $error("bit op outside window");
    property p_set;
        go && req_kind[3] && req_addr < 8'h20 |-> reg_wr && reg_wdata == (keep | 8'h01 << req_bit);
    endproperty
    a_set: assert property (p_set) else $error("bit set merge wrong");
    property p_clear;
        go && req_kind[4] && req_addr < 8'h20 |-> reg_wdata == (keep & ~(8'h01 << req_bit));
    endproperty
    a_clear: assert property (p_clear) else $error("bit clear merge wrong");
    property p_io; go && |req_kind[2:1] && req_addr < 8'h40 |-> reg_sel && reg_addr == req_addr;
    endproperty
    a_io: assert property (p_io) else $error("direct access address wrong");
    property p_read; go && req_kind[1] && req_addr < 8'h40 |-> reg_rd && !reg_wr; endproperty
    a_read: assert property (p_read) else $error("direct read strobe wrong");
    property p_data;
        go && req_kind[6] && req_addr inside {[8'h20:8'h5F]}
            |-> reg_sel && reg_addr == req_addr - 8'h20;
    endproperty
    a_data: assert property (p_data) else $error("data offset wrong");
    property p_ext; go |-> reg_ext == (req_kind[6] && req_addr > 8'h5F); endproperty
    a_ext: assert property (p_ext) else $error("extended flag wrong");
endmodule // io_space_checker
bind io_space_access_decoder io_space_checker io_space_checker_i (.sys_clk, .resetn, .clk_en,
    .req_valid, .req_kind, .req_addr, .req_bit, .reg_sel, .reg_ext, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .reg_w1c_mask, .resp_error);
`default_nettype wire

//--- verif/periph_model.sv
// Peripheral register file behind the decoder
`timescale 1ns/10ps
`default_nettype none
module periph_model (
    // Register port
    input wire logic sys_clk,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [7:0] reg_w1c_mask
);
    logic [7:0] mem_reg [256] = '{default: 8'hF0};
    // Low registers carry flags in the upper nibble; unselected reads show junk
    assign reg_w1c_mask = (reg_sel && reg_addr < 8'h20) ? 8'hF0 : 8'h00;
    assign reg_rdata = reg_sel ? mem_reg[reg_addr] : ~mem_reg[reg_addr];
    // A one clears a flag, a zero keeps it
    always_ff @(posedge sys_clk) begin
        if (reg_sel && reg_wr) begin
            mem_reg[reg_addr] <= (reg_wdata & ~reg_w1c_mask)
                | (mem_reg[reg_addr] & reg_w1c_mask & ~reg_wdata);
        end
    end
endmodule // periph_model
`default_nettype wire

//--- verif/testbench.sv
// Testbench for the I/O space access decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic sys_clk = 0, resetn = 0, clk_en = 1, req_valid = 0, req_write = 0;
    io_space_pkg::access_kind_type req_kind = io_space_pkg::ACC_NONE;
    logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, reg_addr, reg_wdata, reg_rdata;
    logic [7:0] reg_w1c_mask, resp_rdata;
    logic [2:0] req_bit = 3'h0;
    logic reg_sel, reg_wr, resp_valid, resp_error, resp_skip;
    int failures = 0, total_checks = 0, cycles = 0;
    // Rows: kind, address, refusal expected
    logic [15:0] rows [7] = '{{7'h08, 8'h20, 1'b1}, {7'h20, 8'h1F, 1'b0}, {7'h02, 8'h3F, 1'b0},
        {7'h04, 8'h40, 1'b1}, {7'h40, 8'h1F, 1'b1}, {7'h40, 8'hFF, 1'b0}, {7'h10, 8'h60, 1'b1}};
    io_space_access_decoder io_space_access_decoder_i (.sys_clk, .resetn, .clk_en, .req_valid,
        .req_kind, .req_addr, .req_bit, .req_write, .req_wdata, .reg_sel, .reg_ext(), .reg_addr,
        .reg_rd(), .reg_wr, .reg_wdata, .reg_rdata, .reg_w1c_mask, .resp_valid, .resp_error,
        .resp_rdata, .resp_skip);
    periph_model periph_model_i (.sys_clk, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_w1c_mask);
    // Clock and a ceiling on run length
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 400) begin
            failures++;
            complete_run();
        end
    end
    // One request, answer standing when the task returns
    task automatic op(input logic [6:0] k, input logic [7:0] a, input logic [2:0] b,
        input logic [7:0] d, input logic w);
        @(posedge sys_clk) #1;
        req_valid = 1;
        req_kind = io_space_pkg::access_kind_type'(k);
        req_addr = a;
        req_bit = b;
        req_wdata = d;
        req_write = w;
        @(posedge sys_clk) #1;
        req_valid = 0;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Table first, then flag merges and the data-space views
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        chk("valid in reset", {7'h00, resp_valid}, 8'h00);
        resetn = 1;
        foreach (rows[i]) begin
            op(rows[i][15:9], rows[i][8:1], 3'h0, 8'h00, 1'b0);
            chk("error", {7'h00, resp_error}, {7'h00, rows[i][0]});
            chk("valid", {7'h00, resp_valid}, 8'h01);
        end
        op(7'h08, 8'h05, 3'h2, 8'h00, 1'b0);
        op(7'h08, 8'h05, 3'h5, 8'h00, 1'b0);
        op(7'h02, 8'h05, 3'h0, 8'h00, 1'b0);
        chk("flags after set", resp_rdata, 8'hD4);
        op(7'h20, 8'h05, 3'h6, 8'h00, 1'b0);
        chk("skip", {7'h00, resp_skip}, 8'h01);
        op(7'h10, 8'h05, 3'h2, 8'h00, 1'b0);
        op(7'h40, 8'h25, 3'h0, 8'h00, 1'b0);
        chk("flags after clear", resp_rdata, 8'hD0);
        op(7'h40, 8'h80, 3'h0, 8'h5A, 1'b1);
        op(7'h40, 8'h80, 3'h0, 8'h00, 1'b0);
        chk("extended", resp_rdata, 8'h5A);
        op(7'h04, 8'h3F, 3'h0, 8'hA5, 1'b0);
        op(7'h02, 8'h3F, 3'h0, 8'h00, 1'b0);
        chk("direct top", resp_rdata, 8'hA5);
        op(7'h20, 8'h05, 3'h2, 8'h00, 1'b0);
        chk("no skip", {7'h00, resp_skip}, 8'h00);
        // Frozen cycles: no write lands and the last answer stays
        clk_en = 0;
        op(7'h04, 8'h3F, 3'h0, 8'h11, 1'b0);
        chk("frozen data", resp_rdata, 8'hD0);
        chk("frozen valid", {7'h00, resp_valid}, 8'h01);
        clk_en = 1;
        op(7'h02, 8'h3F, 3'h0, 8'h00, 1'b0);
        chk("no frozen write", resp_rdata, 8'hA5);
        // Reset in mid-run clears the answer, not the registers behind it
        resetn = 0;
        @(posedge sys_clk) #1;
        chk("valid after reset", {7'h00, resp_valid}, 8'h00);
        chk("data after reset", resp_rdata, 8'h00);
        resetn = 1;
        op(7'h02, 8'h3F, 3'h0, 8'h00, 1'b0);
        chk("read after reset", resp_rdata, 8'hA5);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
